// file: logic/mcs_master_sched.sv
`timescale 1ns/100ps
`include "mcs_regs.svh"
// Function
// - Block count is register count over 200, plus one for a remainder.
// - A partial last block carries only the leftover words.
// - Retry limit zero keeps the port running despite backplane errors.
// - Nonzero limit halts the port after that many consecutive errors.
// - One good backplane transfer ends the halt.
// - Status pointer of minus one suppresses the status copy.
// - Pointer 0 to 4939 stores status at that location.
// - Replies to received requests wait at least the minimum delay.
// - A command with no reply within the timeout has failed.
// - A failed request is reissued up to the retry limit.
// - Commands other than retries are spaced by at least the inter-command gap.
// - An erroring command is skipped for the holdoff list cycles.
// - Enable code 0 is never issued.
// - Enable code 1 issues once its poll interval has elapsed.
// - Enable code 2 issues write commands only on changed data.
// - Start address is 0..4999, or 0..65535 for bit commands.
// - Swap code reorders read data: none, words, all, bytes.
// - Only function codes 7, 11, 12 and 13 are accepted.
// - Function 11 targets the node in the node field.
// - Count sent, replies, errors; refresh status per read block.
// - Count block transfers and errors; keep current and last error.
// - Data pages of at most 200 words at their array position.
module mcs_master_sched #(
   parameter int MS_CYCLES = `MCS_MS_CYC
)
(
   input logic sys_clk,
   input logic sys_rst,
   input logic [7:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input logic bp_ok,
   input logic bp_err,
   input logic [4:0] blk_ev,
   input logic [`MCS_NUM_ENT-1:0] data_changed,
   input logic req_rx,
   output logic reply_go,
   output logic cmd_valid,
   output mcs_pkg::mcs_cmd_s cmd,
   input logic reply_valid,
   input logic [31:0] reply_data,
   output logic [31:0] reply_swapped,
   output logic comm_halt,
   output logic status_copy_we,
   output logic [15:0] status_copy_addr,
   output logic status_refresh,
   output logic [1:0][15:0] page_off,
   output logic [1:0][15:0] page_words
);
   localparam int NE = `MCS_NUM_ENT;
   localparam int CI_RD = `MCS_OFF_READ_CNT >> 2;
   localparam int CI_WR = `MCS_OFF_WRITE_CNT >> 2;
   localparam int CI_BP = `MCS_OFF_BP_LIMIT >> 2;
   localparam int CI_SP = `MCS_OFF_STPTR >> 2;
   localparam int CI_MR = `MCS_OFF_MIN_REPLY >> 2;
   localparam int CI_TO = `MCS_OFF_TIMEOUT >> 2;
   localparam int CI_RT = `MCS_OFF_RETRY >> 2;
   localparam int CI_GP = `MCS_OFF_GAP >> 2;
   localparam int CI_HO = `MCS_OFF_HOLDOFF >> 2;
   localparam int NC = `MCS_OFF_STATUS >> 2;

   function automatic logic [15:0] blk_cnt(input logic [15:0] n);
      blk_cnt = n / `MCS_BLK_WORDS
         + ((n % `MCS_BLK_WORDS) != 16'h0000 ? 16'h0001 : 16'h0000);
   endfunction

   function automatic logic fn_ok(input logic [3:0] f);
      fn_ok = (f == `MCS_FN_BIT) || (f == `MCS_FN_NODE)
         || (f == `MCS_FN_WR_A) || (f == `MCS_FN_WR_B);
   endfunction

   function automatic logic fn_wr(input logic [3:0] f);
      fn_wr = (f == `MCS_FN_WR_A) || (f == `MCS_FN_WR_B);
   endfunction

   function automatic logic [31:0] swap32(input logic [31:0] d,
                                          input logic [1:0] c);
      case (c)
         2'h1: swap32 = {d[15:0], d[31:16]};
         2'h2: swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
         2'h3: swap32 = {d[23:16], d[31:24], d[7:0], d[15:8]};
         default: swap32 = d;
      endcase
   endfunction

   // Bus slave and configuration
   logic [15:0] cfg_r [NC];
   logic [15:0] cfg_nxt [NC];
   mcs_pkg::mcs_entry_s ent_r [NE];
   mcs_pkg::mcs_entry_s ent_nxt [NE];
   logic [15:0] poll_r [NE];
   logic [15:0] poll_nxt [NE];
   logic wreq_r, wreq_nxt;
   logic [31:0] rdata_r, rdata_nxt, rsel;
   logic [7:0] bsel;
   logic [15:0] blk_r [6];
   logic [15:0] sent_r, recv_r, cerr_r, cur_err_r, last_err_r;
   logic halt_r;
   mcs_pkg::mcs_state_e st_r;
   logic [15:0] nblk [2];

   assign nblk[0] = blk_cnt(cfg_r[CI_RD]);
   assign nblk[1] = blk_cnt(cfg_r[CI_WR]);

   always_comb
   begin
      rsel = 32'h0000_0000;
      bsel = avs_address - `MCS_OFF_BLK;
      if (avs_address < `MCS_OFF_STATUS)
         rsel = {16'h0000, cfg_r[avs_address[5:2]]};
      else if (avs_address >= `MCS_OFF_ENT && avs_address < `MCS_OFF_END)
         rsel = avs_address[2] ? {16'h0000, poll_r[avs_address[4:3]]}
                               : ent_r[avs_address[4:3]];
      else if (avs_address >= `MCS_OFF_BLK && avs_address < `MCS_OFF_BLKS)
         rsel = {16'h0000, blk_r[bsel[4:2]]};
      else
         case (avs_address)
            `MCS_OFF_STATUS: rsel = {last_err_r[7:0], cur_err_r[7:0],
                                     12'h000, st_r, halt_r};
            `MCS_OFF_SENT: rsel = {16'h0000, sent_r};
            `MCS_OFF_RECV: rsel = {16'h0000, recv_r};
            `MCS_OFF_CERR: rsel = {16'h0000, cerr_r};
            `MCS_OFF_BLKS: rsel = {nblk[1], nblk[0]};
            default: rsel = 32'h0000_0000;
         endcase
   end

   always_comb
   begin
      cfg_nxt = cfg_r;
      ent_nxt = ent_r;
      poll_nxt = poll_r;
      // Every access answers in the second cycle; no long stalls
      wreq_nxt = !((avs_read || avs_write) && wreq_r);
      rdata_nxt = ((avs_read || avs_write) && wreq_r) ? rsel : rdata_r;
      if (avs_write && !wreq_r)
      begin
         if (avs_address < `MCS_OFF_STATUS)
            cfg_nxt[avs_address[5:2]] = avs_writedata[15:0];
         else if (avs_address >= `MCS_OFF_ENT
                  && avs_address < `MCS_OFF_END)
         begin
            if (avs_address[2])
               poll_nxt[avs_address[4:3]] = avs_writedata[15:0];
            else
               ent_nxt[avs_address[4:3]] = avs_writedata;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NC; i++)
            cfg_r[i] <= 16'h0000;
         cfg_r[CI_SP] <= `MCS_STPTR_RST;
         for (int i = 0; i < NE; i++)
         begin
            ent_r[i] <= 32'h0000_0000;
            poll_r[i] <= 16'h0000;
         end
         wreq_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         ent_r <= ent_nxt;
         poll_r <= poll_nxt;
         wreq_r <= wreq_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wreq_r;

   // Time base: ms tick and second tick
   logic [31:0] ms_cnt_r, ms_cnt_nxt;
   logic [15:0] sec_cnt_r, sec_cnt_nxt;
   logic tick, sec_tick;
   assign tick = (ms_cnt_r == 32'(MS_CYCLES - 1));
   assign sec_tick = tick && (sec_cnt_r == `MCS_MS_PER_S - 16'h0001);

   always_comb
   begin
      ms_cnt_nxt = tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
      sec_cnt_nxt = sec_cnt_r;
      if (tick)
         sec_cnt_nxt = sec_tick ? 16'h0000 : sec_cnt_r + 16'h0001;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ms_cnt_r <= 32'h0000_0000;
         sec_cnt_r <= 16'h0000;
      end
      else
      begin
         ms_cnt_r <= ms_cnt_nxt;
         sec_cnt_r <= sec_cnt_nxt;
      end
   end

   // Backplane health and status copy
   logic [15:0] bp_run_r, bp_run_nxt;
   logic halt_nxt, scw_r, scw_nxt, srf_r;
   logic [15:0] sca_r;

   always_comb
   begin
      bp_run_nxt = bp_run_r;
      halt_nxt = halt_r;
      if (bp_ok)
      begin
         bp_run_nxt = 16'h0000;
         halt_nxt = 1'b0;
      end
      else if (bp_err)
      begin
         if (bp_run_r != 16'hFFFF)
            bp_run_nxt = bp_run_r + 16'h0001;
         if (bp_run_nxt >= cfg_r[CI_BP])
            halt_nxt = 1'b1;
      end
      if (cfg_r[CI_BP] == 16'h0000)
         halt_nxt = 1'b0;
      scw_nxt = blk_ev[0] && cfg_r[CI_SP] != `MCS_STPTR_RST
         && cfg_r[CI_SP] <= `MCS_STPTR_MAX;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         bp_run_r <= 16'h0000;
         halt_r <= 1'b0;
         scw_r <= 1'b0;
         sca_r <= 16'h0000;
         srf_r <= 1'b0;
      end
      else
      begin
         bp_run_r <= bp_run_nxt;
         halt_r <= halt_nxt;
         scw_r <= scw_nxt;
         sca_r <= cfg_r[CI_SP];
         srf_r <= blk_ev[0];
      end
   end

   assign comm_halt = halt_r;
   assign status_copy_we = scw_r;
   assign status_copy_addr = sca_r;
   assign status_refresh = srf_r;

   // Block statistics and paging
   logic [5:0] bev;
   assign bev = {bp_err, blk_ev};
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : g_blk
         logic [15:0] nxt;
         always_comb
            nxt = bev[g] ? blk_r[g] + 16'h0001 : blk_r[g];
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
               blk_r[g] <= 16'h0000;
            else
               blk_r[g] <= nxt;
         end
      end
      for (g = 0; g < 2; g++)
      begin : g_page
         logic [15:0] idx_r, idx_nxt, off_nxt, wds_nxt, rem;
         logic [15:0] off_r, wds_r;
         always_comb
         begin
            rem = cfg_r[CI_RD + g] % `MCS_BLK_WORDS;
            idx_nxt = idx_r;
            if (blk_ev[g])
               idx_nxt = (idx_r + 16'h0001 >= nblk[g]) ? 16'h0000
                                                         : idx_r + 16'h0001;
            off_nxt = 16'(idx_nxt * `MCS_BLK_WORDS);
            wds_nxt = (idx_nxt + 16'h0001 == nblk[g] && rem != 16'h0000)
               ? rem : `MCS_BLK_WORDS;
         end
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
            begin
               idx_r <= 16'h0000;
               off_r <= 16'h0000;
               wds_r <= 16'h0000;
            end
            else
            begin
               idx_r <= idx_nxt;
               off_r <= off_nxt;
               wds_r <= wds_nxt;
            end
         end
         assign page_off[g] = off_r;
         assign page_words[g] = wds_r;
      end
   endgenerate

   // Reply pacing for received requests
   logic [16:0] rep_tmr_r, rep_tmr_nxt;
   logic rep_busy_r, rep_busy_nxt, rgo_r, rgo_nxt;

   always_comb
   begin
      rep_tmr_nxt = rep_tmr_r;
      rep_busy_nxt = rep_busy_r;
      rgo_nxt = 1'b0;
      if (req_rx)
      begin
         // One extra tick because the first tick arrives at a random phase
         rep_tmr_nxt = {1'b0, cfg_r[CI_MR]} + 17'h00001;
         rep_busy_nxt = 1'b1;
      end
      else if (rep_busy_r && tick)
      begin
         rep_tmr_nxt = rep_tmr_r - 17'h00001;
         if (rep_tmr_r == 17'h00001)
         begin
            rep_busy_nxt = 1'b0;
            rgo_nxt = !halt_r;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rep_tmr_r <= 17'h00000;
         rep_busy_r <= 1'b0;
         rgo_r <= 1'b0;
      end
      else
      begin
         rep_tmr_r <= rep_tmr_nxt;
         rep_busy_r <= rep_busy_nxt;
         rgo_r <= rgo_nxt;
      end
   end

   assign reply_go = rgo_r;

   // Command list scheduler
   mcs_pkg::mcs_state_e st_nxt;
   logic [1:0] idx_r, idx_nxt;
   logic [16:0] tmr_r, tmr_nxt;
   logic [15:0] rty_r, rty_nxt, sent_nxt, recv_nxt, cerr_nxt;
   logic [15:0] cur_nxt, last_nxt;
   logic [15:0] hold_r [NE];
   logic [15:0] hold_nxt [NE];
   logic [15:0] el_r [NE];
   logic [15:0] el_nxt [NE];
   logic [NE-1:0] pend_r, pend_nxt;
   logic cv_r, cv_nxt;
   mcs_pkg::mcs_cmd_s cmd_r, cmd_nxt;
   logic [31:0] rsw_r, rsw_nxt;
   mcs_pkg::mcs_entry_s ce;
   logic elig, adv;

   always_comb
   begin
      ce = ent_r[idx_r];
      elig = fn_ok(ce.func) && hold_r[idx_r] == 16'h0000
         && (ce.func == `MCS_FN_BIT
             || ce.addr <= `MCS_REG_ADDR_MAX)
         && ((ce.en == 2'h1 && el_r[idx_r] >= poll_r[idx_r])
             || (ce.en == 2'h2 && fn_wr(ce.func)
                 && pend_r[idx_r]));
      st_nxt = st_r;
      idx_nxt = idx_r;
      tmr_nxt = tmr_r;
      rty_nxt = rty_r;
      sent_nxt = sent_r;
      recv_nxt = recv_r;
      cerr_nxt = cerr_r;
      cur_nxt = cur_err_r;
      last_nxt = last_err_r;
      hold_nxt = hold_r;
      el_nxt = el_r;
      cv_nxt = 1'b0;
      cmd_nxt = cmd_r;
      rsw_nxt = rsw_r;
      adv = 1'b0;
      pend_nxt = pend_r;
      for (int i = 0; i < NE; i++)
         if (sec_tick && el_r[i] != 16'hFFFF)
            el_nxt[i] = el_r[i] + 16'h0001;
      case (st_r)
         mcs_pkg::MCS_IDLE:
            st_nxt = mcs_pkg::MCS_SCAN;
         mcs_pkg::MCS_SCAN:
            if (elig)
               st_nxt = mcs_pkg::MCS_ISSUE;
            else
               adv = 1'b1;
         mcs_pkg::MCS_ISSUE:
         begin
            cv_nxt = 1'b1;
            cmd_nxt = {ce.addr, ce.node, ce.func, ce.swap};
            sent_nxt = sent_r + 16'h0001;
            el_nxt[idx_r] = 16'h0000;
            pend_nxt[idx_r] = 1'b0;
            tmr_nxt = {1'b0, cfg_r[CI_TO]} + 17'h00001;
            st_nxt = mcs_pkg::MCS_WAIT;
         end
         mcs_pkg::MCS_WAIT:
            if (reply_valid)
            begin
               recv_nxt = recv_r + 16'h0001;
               rsw_nxt = swap32(reply_data, cmd_r.swap);
               cur_nxt = 16'h0000;
               rty_nxt = 16'h0000;
               tmr_nxt = {1'b0, cfg_r[CI_GP]} + 17'h00001;
               st_nxt = mcs_pkg::MCS_GAP;
            end
            else if (tick)
            begin
               tmr_nxt = tmr_r - 17'h00001;
               if (tmr_r <= 17'h00001)
               begin
                  if (rty_r < cfg_r[CI_RT])
                  begin
                     rty_nxt = rty_r + 16'h0001;
                     st_nxt = mcs_pkg::MCS_ISSUE;
                  end
                  else
                  begin
                     cerr_nxt = cerr_r + 16'h0001;
                     hold_nxt[idx_r] = cfg_r[CI_HO];
                     cur_nxt = {14'h0000, idx_r} + 16'h0001;
                     last_nxt = cur_nxt;
                     rty_nxt = 16'h0000;
                     tmr_nxt = {1'b0, cfg_r[CI_GP]} + 17'h00001;
                     st_nxt = mcs_pkg::MCS_GAP;
                  end
               end
            end
         mcs_pkg::MCS_GAP:
            if (tick)
            begin
               tmr_nxt = tmr_r - 17'h00001;
               if (tmr_r <= 17'h00001)
               begin
                  adv = 1'b1;
                  st_nxt = mcs_pkg::MCS_SCAN;
               end
            end
         default:
            st_nxt = mcs_pkg::MCS_IDLE;
      endcase
      if (adv)
      begin
         idx_nxt = idx_r + 2'h1;
         if (idx_r == 2'(NE - 1))
            for (int i = 0; i < NE; i++)
               if (hold_nxt[i] != 16'h0000)
                  hold_nxt[i] = hold_nxt[i] - 16'h0001;
      end
      // Set wins over the clear made by an issue in the same cycle
      pend_nxt = pend_nxt | data_changed;
      if (halt_r || !cfg_r[0][0])
      begin
         st_nxt = mcs_pkg::MCS_IDLE;
         cv_nxt = 1'b0;
         rty_nxt = 16'h0000;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_r <= mcs_pkg::MCS_IDLE;
         idx_r <= 2'h0;
         tmr_r <= 17'h00000;
         rty_r <= 16'h0000;
         sent_r <= 16'h0000;
         recv_r <= 16'h0000;
         cerr_r <= 16'h0000;
         cur_err_r <= 16'h0000;
         last_err_r <= 16'h0000;
         for (int i = 0; i < NE; i++)
         begin
            hold_r[i] <= 16'h0000;
            el_r[i] <= 16'hFFFF;
         end
         pend_r <= '0;
         cv_r <= 1'b0;
         cmd_r <= '0;
         rsw_r <= 32'h0000_0000;
      end
      else
      begin
         st_r <= st_nxt;
         idx_r <= idx_nxt;
         tmr_r <= tmr_nxt;
         rty_r <= rty_nxt;
         sent_r <= sent_nxt;
         recv_r <= recv_nxt;
         cerr_r <= cerr_nxt;
         cur_err_r <= cur_nxt;
         last_err_r <= last_nxt;
         hold_r <= hold_nxt;
         el_r <= el_nxt;
         pend_r <= pend_nxt;
         cv_r <= cv_nxt;
         cmd_r <= cmd_nxt;
         rsw_r <= rsw_nxt;
      end
   end

   assign cmd_valid = cv_r;
   assign cmd = cmd_r;
   assign reply_swapped = rsw_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_issue;
      st_r == mcs_pkg::MCS_ISSUE && !halt_r && cfg_r[0][0];
   endsequence
   sequence s_reply;
      st_r == mcs_pkg::MCS_WAIT && reply_valid && !halt_r && cfg_r[0][0];
   endsequence

   a_halt_on_limit: assert property (bp_err && !bp_ok
      && cfg_r[CI_BP] != 16'h0000 && bp_run_r + 16'h0001 >= cfg_r[CI_BP]
      |=> halt_r) else $error("halt missed at retry limit");
   a_no_halt_zero: assert property (cfg_r[CI_BP] == 16'h0000
      |=> !halt_r) else $error("halted with zero retry limit");
   a_resume_ok: assert property (bp_ok |=> !halt_r
      ##1 !halt_r || $past(bp_err)) else $error("no resume after good");
   a_stptr_off: assert property (blk_ev[0]
      |=> status_copy_we == ($past(cfg_r[CI_SP]) <= `MCS_STPTR_MAX))
      else $error("status copy against pointer");
   a_issue_enabled: assert property (s_issue |=> cv_r
      && ent_r[idx_r].en != 2'h0) else $error("disabled command issued");
   a_func_valid: assert property (cv_r |-> fn_ok(cmd_r.func))
      else $error("bad function code issued");
   a_gap_hold: assert property (st_r == mcs_pkg::MCS_GAP
      && !tick |=> st_r != mcs_pkg::MCS_SCAN)
      else $error("gap left without a tick");
   a_reply_count: assert property (s_reply |=> recv_r
      == $past(recv_r) + 16'h0001 && st_r != mcs_pkg::MCS_WAIT)
      else $error("reply not counted");
   a_sent_count: assert property (s_issue |=> cv_r
      ##1 sent_r == $past(sent_r, 2) + 16'h0001)
      else $error("issue not counted");
endmodule

// file: logic/mcs_pkg.sv
package mcs_pkg;
   typedef enum logic [2:0] {
      MCS_IDLE = 3'h0,
      MCS_SCAN = 3'h1,
      MCS_ISSUE = 3'h2,
      MCS_WAIT = 3'h3,
      MCS_GAP = 3'h4
   } mcs_state_e;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] node;
      logic [1:0] swap;
      logic [3:0] func;
      logic [1:0] en;
   } mcs_entry_s;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] node;
      logic [3:0] func;
      logic [1:0] swap;
   } mcs_cmd_s;
endpackage

// file: logic/mcs_regs.svh
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
`define MCS_BLK_WORDS 16'h00C8
`define MCS_NUM_ENT 4
`define MCS_OFF_CTRL 8'h00
`define MCS_OFF_READ_CNT 8'h04
`define MCS_OFF_WRITE_CNT 8'h08
`define MCS_OFF_BP_LIMIT 8'h0C
`define MCS_OFF_STPTR 8'h10
`define MCS_OFF_MIN_REPLY 8'h14
`define MCS_OFF_TIMEOUT 8'h18
`define MCS_OFF_RETRY 8'h1C
`define MCS_OFF_GAP 8'h20
`define MCS_OFF_HOLDOFF 8'h24
`define MCS_OFF_STATUS 8'h28
`define MCS_OFF_SENT 8'h2C
`define MCS_OFF_RECV 8'h30
`define MCS_OFF_CERR 8'h34
`define MCS_OFF_BLK 8'h38
`define MCS_OFF_BLKS 8'h50
`define MCS_OFF_ENT 8'h80
`define MCS_OFF_END 8'hA0
`define MCS_STPTR_RST 16'hFFFF
`define MCS_STPTR_MAX 16'h134B
`define MCS_REG_ADDR_MAX 16'h1387
`define MCS_FN_BIT 4'h7
`define MCS_FN_NODE 4'hB
`define MCS_FN_WR_A 4'hC
`define MCS_FN_WR_B 4'hD
`define MCS_CLK_MHZ 100
`define MCS_TICK_US 1000
`define MCS_MS_CYC (`MCS_TICK_US * `MCS_CLK_MHZ)
`define MCS_MS_PER_S 16'h03E8
`endif

// file: tb/mcs_master_sched_tb_top.sv
`timescale 1ns/100ps
`include "mcs_regs.svh"
module mcs_master_sched_tb_top;
   logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, reply_data, reply_swapped;
   logic avs_waitrequest, bp_ok = 0, bp_err = 0, req_rx = 0, reply_go;
   logic [4:0] blk_ev = 5'h00;
   logic cmd_valid, reply_valid, comm_halt, status_copy_we, status_refresh;
   logic mute = 0;
   logic [3:0] data_changed = 4'h0;
   logic [3:0] lag = 4'h1;
   logic [15:0] status_copy_addr;
   logic [1:0][15:0] page_off, page_words;
   mcs_pkg::mcs_cmd_s cmd;
   int err_total = 0, checks_done = 0, cyc = 0, n;
   logic [31:0] d, sum;
   logic [31:0] sw [4] = '{32'h11223344, 32'h33441122, 32'h44332211,
                           32'h22114433};
   always #5 sys_clk = ~sys_clk;
   mcs_master_sched #(.MS_CYCLES(10)) dut_u (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bp_ok(bp_ok), .bp_err(bp_err), .blk_ev(blk_ev),
      .data_changed(data_changed), .req_rx(req_rx), .reply_go(reply_go),
      .cmd_valid(cmd_valid), .cmd(cmd), .reply_valid(reply_valid),
      .reply_data(reply_data), .reply_swapped(reply_swapped),
      .comm_halt(comm_halt), .status_copy_we(status_copy_we),
      .status_copy_addr(status_copy_addr), .status_refresh(status_refresh),
      .page_off(page_off), .page_words(page_words));
   mcs_slave_model far_u (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
      .mute(mute), .lag(lag), .answer(sw[0]), .reply_valid(reply_valid),
      .reply_data(reply_data));
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e)
      begin
         $display("wrong value %s exp %h got %h", nm, e, g);
         err_total++;
      end
   endtask
   // One access per call; the edge at the start keeps requests apart
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic kick(input logic [7:0] m);
      @(posedge sys_clk);
      {req_rx, bp_err, bp_ok, blk_ev} <= m;
      @(posedge sys_clk);
      {req_rx, bp_err, bp_ok, blk_ev} <= 8'h00;
      #1;
   endtask
   task automatic wait_cmd();
      n = 0;
      do begin @(posedge sys_clk); n++; end while (cmd_valid !== 1'b1);
   endtask
   task automatic t_reset();
      acc(0, `MCS_OFF_STPTR, 0); chk("ptr", 32'h0000FFFF, d);
      acc(0, `MCS_OFF_SENT, 0); chk("sent", 32'h0, d);
      acc(0, 8'h60, 0); chk("hole", 32'h0, d);
   endtask
   task automatic t_pages();
      acc(1, `MCS_OFF_READ_CNT, 32'h1C2);
      acc(1, `MCS_OFF_WRITE_CNT, 32'h190);
      acc(0, `MCS_OFF_BLKS, 0); chk("blks", 32'h00020003, d);
      sum = 0;
      for (int k = 1; k < 4; k++)
      begin
         kick(8'h01);
         chk("pageoff", (k % 3) * 200, page_off[0]);
         sum += page_words[0];
         chk("refresh", 1, status_refresh);
         chk("nocopy", 0, status_copy_we);
         chk("pagemax", 1, page_words[0] <= 16'h00C8);
      end
      chk("pagesum", 32'h1C2, sum);
      acc(0, `MCS_OFF_BLK, 0); chk("rdblk", 32'h3, d);
      acc(1, `MCS_OFF_STPTR, 32'h134B);
      kick(8'h01);
      chk("copy", 1, status_copy_we);
      chk("copyad", 32'h134B, status_copy_addr);
   endtask
   task automatic t_bp();
      acc(1, `MCS_OFF_BP_LIMIT, 32'h3);
      repeat (2) kick(8'h40);
      chk("early", 0, comm_halt);
      kick(8'h40); chk("halt", 1, comm_halt);
      kick(8'h20); chk("resume", 0, comm_halt);
      acc(1, `MCS_OFF_BP_LIMIT, 32'h0);
      repeat (4) kick(8'h40);
      chk("nolimit", 0, comm_halt);
      acc(0, 8'h4C, 0); chk("blkerr", 32'h7, d);
   endtask
   task automatic t_cmds();
      acc(1, `MCS_OFF_TIMEOUT, 32'h5);
      acc(1, `MCS_OFF_GAP, 32'h2);
      acc(1, 8'h88, 32'hAAAA0000 | 32'h1C);
      acc(1, `MCS_OFF_CTRL, 32'h1);
      for (int s = 0; s < 4; s++)
      begin
         lag <= 4'(1 + 2 * s);
         acc(1, `MCS_OFF_ENT, {16'h1234, 8'(5 + s), 2'(s), 4'hB, 2'h1});
         wait_cmd();
         wait_cmd();
         // Reply comes 2 + lag cycles after issue, then 2 ms of gap
         chk("gap", 1, n >= 23 + 2 * s);
         chk("addr", 32'h1234, cmd.addr);
         chk("node", 5 + s, cmd.node);
         chk("func", 32'hB, cmd.func);
         do @(posedge sys_clk); while (reply_valid !== 1'b1);
         @(posedge sys_clk);
         #1;
         chk("swap", sw[s], reply_swapped);
      end
   endtask
   task automatic t_timeout();
      acc(1, `MCS_OFF_CTRL, 32'h0);
      mute <= 1'b1;
      acc(1, `MCS_OFF_RETRY, 32'h1);
      acc(1, `MCS_OFF_TIMEOUT, 32'h1);
      acc(0, `MCS_OFF_CERR, 0);
      sum = d;
      acc(1, `MCS_OFF_CTRL, 32'h1);
      wait_cmd();
      wait_cmd();
      // Retry no sooner than the 1 ms timeout, and no later than 2 ms
      chk("timeout", 1, n >= 10 && n <= 22);
      repeat (25) @(posedge sys_clk);
      acc(0, `MCS_OFF_CERR, 0); chk("cerr", sum + 1, d);
      acc(0, `MCS_OFF_STATUS, 0);
      chk("errix", 32'h0101, d[31:16]);
   endtask
   task automatic t_event();
      acc(1, `MCS_OFF_CTRL, 32'h0);
      mute <= 1'b0;
      lag <= 4'h1;
      acc(1, `MCS_OFF_ENT, {16'h0010, 8'h02, 2'h0, 4'hC, 2'h2});
      acc(1, 8'h88, {16'h0020, 8'h03, 2'h0, 4'hB, 2'h2});
      acc(1, 8'h90, {16'h0030, 8'h04, 2'h0, 4'h3, 2'h1});
      acc(1, 8'h98, {16'h1388, 8'h05, 2'h0, 4'hC, 2'h1});
      acc(0, `MCS_OFF_SENT, 0);
      sum = d;
      acc(1, `MCS_OFF_CTRL, 32'h1);
      repeat (60) @(posedge sys_clk);
      acc(0, `MCS_OFF_SENT, 0);
      chk("evidle", sum, d);
      data_changed <= 4'h3;
      @(posedge sys_clk);
      data_changed <= 4'h0;
      wait_cmd();
      chk("evaddr", 32'h0010, cmd.addr);
      repeat (60) @(posedge sys_clk);
      acc(0, `MCS_OFF_SENT, 0);
      chk("evonce", sum + 1, d);
   endtask
   task automatic t_reply();
      acc(1, `MCS_OFF_MIN_REPLY, 32'h3);
      kick(8'h80);
      n = 0;
      while (reply_go !== 1'b1 && n < 200)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk("pace", 1, n >= 29 && n < 200);
   endtask
   initial
   begin
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_pages();
      t_bp();
      t_cmds();
      t_timeout();
      t_event();
      t_reply();
      tally_and_finish();
   end
endmodule

// file: tb/mcs_slave_model.sv
`timescale 1ns/100ps
module mcs_slave_model (
   input wire logic sys_clk,
   input wire logic cmd_valid,
   input wire logic mute,
   input wire logic [3:0] lag,
   input wire logic [31:0] answer,
   output logic reply_valid,
   output logic [31:0] reply_data
);
   // Silent when muted, so the master's timeout path is exercised
   initial
   begin
      reply_valid = 1'b0;
      reply_data = 32'h0;
      forever
      begin
         @(posedge sys_clk);
         if (cmd_valid && !mute)
         begin
            repeat (lag) @(posedge sys_clk);
            reply_valid <= 1'b1;
            reply_data <= answer;
            @(posedge sys_clk);
            reply_valid <= 1'b0;
            reply_data <= ~answer;
         end
      end
   end
endmodule
